// [verilog/dpll_clk_defines.svh]
// shared constants of the reference and derived-clock block
`ifndef DPLL_CLK_DEFINES_SVH
`define DPLL_CLK_DEFINES_SVH

// -------------------------------------------------------------
// timing figures
// -------------------------------------------------------------
`define CLK_HZ 64'h2FAF080         // 50 MHz system clock
`define CLK_NS 64'h14              // 20 ns period
`define FRAME_NS 64'h1E848         // 125000 ns, one 8 kHz frame
`define REF_TIMEOUT_NS 64'h3D090   // 250000 ns without an edge
`define FP_244_NS 64'hF4
`define FP_122_NS 64'h7A
`define FP_61_NS 64'h3D
`define CYC_UP(ns) (((ns) + `CLK_NS - 64'h1) / `CLK_NS)

// -------------------------------------------------------------
// output and reference frequencies in Hz
// -------------------------------------------------------------
`define HS32_HZ 64'h1F40000        // 32.768 MHz
`define HS65_HZ 64'h3E80000        // 65.536 MHz
`define T1_HZ 64'h178F40           // 1.544 MHz
`define SC4_HZ 64'h3E8000          // 4.096 MHz
`define SC8_HZ 64'h7D0000          // 8.192 MHz
`define SC16_HZ 64'hFA0000         // 16.384 MHz
`define NCO_ONE 64'h100000000      // accumulator modulus
`define DIV_8K 9'h001              // reference edges per frame
`define DIV_T1 9'h0C1              // 193 at 1.544 MHz
`define DIV_E1 9'h100              // 256 at 2.048 MHz

// -------------------------------------------------------------
// register map and field positions
// -------------------------------------------------------------
`define CTRL_OFS 12'h000
`define RATE_OFS 12'h004
`define STAT_OFS 12'h008
`define CTRL_MASK 32'h0007FFFF
`define CTRL_RST 32'h00000000
`define RATE_RST 10'h000
`define C_EXT 0
`define C_FAST 1
`define C_NDIV 2
`define C_NSEL 3
`define C_PSEL 5
`define C_SSEL 8
`define C_SCK0 11
`define C_SCK1 13
`define C_FPW0 15
`define C_FPW1 17
`define S_PRI_LOSS 0
`define S_SEC_LOSS 1
`define S_HOLD 2
`define S_ACT 3
`define S_LOST 8
`define NUM_REFS 5

`endif

// [verilog/dpll_clk_pkg.sv]
// types and decode functions of the reference and derived-clock block
`include "dpll_clk_defines.svh"
package dpll_clk_pkg;

  typedef enum logic [1:0] {RATE_8K, RATE_T1, RATE_E1} rate_t;
  typedef enum logic [1:0] {SCK_4M, SCK_8M, SCK_16M} sck_t;
  typedef enum logic [1:0] {FPW_244, FPW_122, FPW_61} fpw_t;
  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_HOLD} src_t;

  // phase step for a given output frequency
  function automatic logic [31:0] inc_of(input logic [63:0] hz);
    logic [63:0] t;
    t = (hz * `NCO_ONE) / `CLK_HZ;
    return t[31:0];
  endfunction

  // reference edges that make up one 8 kHz frame
  function automatic logic [8:0] div_of(input logic [1:0] r);
    unique case (r)
      RATE_T1: return `DIV_T1;
      RATE_E1: return `DIV_E1;
      default: return `DIV_8K;
    endcase
  endfunction

  function automatic logic [31:0] sck_inc(input logic [1:0] s);
    unique case (s)
      SCK_8M: return inc_of(`SC8_HZ);
      SCK_16M: return inc_of(`SC16_HZ);
      default: return inc_of(`SC4_HZ);
    endcase
  endfunction

  // least time, so widths round up to whole cycles
  function automatic logic [4:0] fp_cyc(input logic [1:0] w);
    logic [63:0] c;
    unique case (w)
      FPW_122: c = `CYC_UP(`FP_122_NS);
      FPW_61: c = `CYC_UP(`FP_61_NS);
      default: c = `CYC_UP(`FP_244_NS);
    endcase
    return c[4:0];
  endfunction

endpackage

// [verilog/ref_activity.sv]
// edge detector and loss-of-activity monitor for one reference input
`timescale 1ns/1ps
module ref_activity #(
  parameter int TIMEOUT = 12500
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ref_in,
  output logic rise,
  output logic lost
);
  logic prev_q, prev_d, lost_q, lost_d;
  logic [15:0] cnt_q, cnt_d;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // any rate is accepted: only the gap between edges is policed
  always_comb begin
    rise = ref_in & ~prev_q;
    prev_d = ref_in;
    cnt_d = cnt_q;
    lost_d = lost_q;
    if (rise) begin
      cnt_d = 16'h0;
      lost_d = 1'b0;
    end else if (cnt_q == 16'(TIMEOUT - 1)) begin
      lost_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      cnt_q <= 16'h0;
      lost_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      lost_q <= lost_d;
    end
  end

  assign lost = lost_q;

  a_rise_clears: assert property (rise |=> !lost)
    else $error("loss flag stayed set after a reference edge");
endmodule

// [verilog/nco_clock.sv]
// phase-accumulator clock generator with frame realignment
`timescale 1ns/1ps
module nco_clock #(
  parameter int W = 32
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] inc,
  input wire logic sync,
  output logic clk_out
);
  logic [W-1:0] acc_q, acc_d;
  logic out_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // sync zeroes the phase so every edge lines up with the frame
  always_comb begin
    acc_d = sync ? '0 : acc_q + inc;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_q <= '0;
      out_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      out_q <= acc_d[W-1];
    end
  end

  assign clk_out = out_q;

  a_acc_step: assert property (
    !sync |=> acc_q == W'($past(acc_q) + $past(inc)))
    else $error("accumulator did not advance by its step");
endmodule

// [verilog/dpll_ref_clocks.sv]
// reference selection, loss status and derived clock and frame outputs
//
// How it works
// - bus reference two accepts 8k/1.544M/2.048M
// - four local references accept the same rates
// - network output: chosen local ref, raw or 8k
// - high primary-loss pin means primary invalid
// - high secondary-loss pin means secondary invalid
// - primary failure pin mirrors primary loss bit
// - secondary failure pin mirrors secondary loss bit
// - fast clock 32.768 or 65.536 MHz by bit
// - T1-rate clock output runs at 1.544 MHz
// - frame pulses at 8 kHz, width selectable
// - stream clocks at 4.096, 8.192 or 16.384 MHz
// - drive enable low floats the derived clock and frame pulse outputs; the network output is always driven
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dpll_clk_defines.svh"
module dpll_ref_clocks #(
  parameter int FRAME_CYCLES = int'(`FRAME_NS / `CLK_NS),
  parameter int LOSS_CYCLES = int'(`REF_TIMEOUT_NS / `CLK_NS)
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_timing_ref_2,
  input wire logic [3:0] local_timing_refs,
  input wire logic primary_loss_in,
  input wire logic secondary_loss_in,
  input wire logic output_drive_enable,
  output logic network_ref_out,
  output logic primary_failure_out,
  output logic secondary_failure_out,
  output logic high_speed_clock_out,
  output logic high_speed_clock_out_oe,
  output logic t1_rate_clock_out,
  output logic t1_rate_clock_out_oe,
  output logic stream_clock_out_0,
  output logic stream_clock_out_0_oe,
  output logic stream_clock_out_1,
  output logic stream_clock_out_1_oe,
  output logic stream_frame_pulse_out_0,
  output logic stream_frame_pulse_out_0_oe,
  output logic stream_frame_pulse_out_1,
  output logic stream_frame_pulse_out_1_oe
);
  import dpll_clk_pkg::*;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // rate code of one reference from the packed rate register
  function automatic logic [1:0] rate_of(input logic [9:0] rv,
                                         input logic [2:0] i);
    logic [3:0] b;
    b = {i, 1'b0};
    return (i < 3'(`NUM_REFS)) ? rv[b +: 2] : 2'h0;
  endfunction

  // -------------------------------------------------------------
  // register bus
  // -------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d, act_q, act_d, stat;
  logic [31:0] prdata_q, prdata_d;
  logic [9:0] rate_q, rate_d;
  logic hit, wr_en, frame_start;

  // zero wait states; status writes are dropped without error
  always_comb begin
    hit = (paddr == `CTRL_OFS) || (paddr == `RATE_OFS) ||
          (paddr == `STAT_OFS);
    wr_en = psel && penable && pwrite && hit;
    ctrl_d = ctrl_q;
    rate_d = rate_q;
    prdata_d = prdata_q;
    if (wr_en && paddr == `CTRL_OFS) begin
      ctrl_d = pwdata & `CTRL_MASK;
    end
    if (wr_en && paddr == `RATE_OFS) begin
      rate_d = pwdata[9:0];
    end
    if (psel && !penable) begin
      unique case (paddr)
        `CTRL_OFS: prdata_d = ctrl_q;
        `RATE_OFS: prdata_d = {22'h0, rate_q};
        `STAT_OFS: prdata_d = stat;
        default: prdata_d = 32'h0;
      endcase
    end
  end

  // shadow copy loads only at the frame boundary
  always_comb begin
    act_d = frame_start ? ctrl_q : act_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= `CTRL_RST;
      act_q <= `CTRL_RST;
      rate_q <= `RATE_RST;
      prdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      act_q <= act_d;
      rate_q <= rate_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // -------------------------------------------------------------
  // reference monitors
  // -------------------------------------------------------------
  logic [`NUM_REFS-1:0] refs, rise, mon_lost;
  logic [7:0] rise8, lost8;

  assign refs = {local_timing_refs, bus_timing_ref_2};
  assign rise8 = {3'h0, rise};
  // unused select codes count as permanently lost
  assign lost8 = {3'h7, mon_lost};

  for (genvar g = 0; g < `NUM_REFS; g++) begin : g_mon
    ref_activity #(.TIMEOUT(LOSS_CYCLES)) u_mon (
      .clk(clk),
      .rst_b(rst_b),
      .ref_in(refs[g]),
      .rise(rise[g]),
      .lost(mon_lost[g])
    );
  end

  // -------------------------------------------------------------
  // source selection
  // -------------------------------------------------------------
  src_t src_q, src_d;
  logic [2:0] pri_idx, sec_idx, act_idx;
  logic pri_bad, sec_bad, pri_fail_q, sec_fail_q;

  // external mode trusts the loss pins, otherwise the monitors
  always_comb begin
    pri_idx = act_q[`C_PSEL +: 3];
    sec_idx = act_q[`C_SSEL +: 3];
    pri_bad = act_q[`C_EXT] ? primary_loss_in : lost8[pri_idx];
    sec_bad = act_q[`C_EXT] ? secondary_loss_in : lost8[sec_idx];
    if (!pri_bad) begin
      src_d = SRC_PRI;
    end else if (!sec_bad) begin
      src_d = SRC_SEC;
    end else begin
      src_d = SRC_HOLD;
    end
    act_idx = (src_q == SRC_SEC) ? sec_idx : pri_idx;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      src_q <= SRC_PRI;
      pri_fail_q <= 1'b0;
      sec_fail_q <= 1'b0;
    end else begin
      src_q <= src_d;
      pri_fail_q <= pri_bad;
      sec_fail_q <= sec_bad;
    end
  end

  assign primary_failure_out = pri_fail_q;
  assign secondary_failure_out = sec_fail_q;

  always_comb begin
    stat = 32'h0;
    stat[`S_PRI_LOSS] = pri_bad;
    stat[`S_SEC_LOSS] = sec_bad;
    stat[`S_HOLD] = (src_q == SRC_HOLD);
    stat[`S_ACT +: 3] = act_idx;
    stat[`S_LOST +: `NUM_REFS] = mon_lost;
  end

  // -------------------------------------------------------------
  // frame timebase
  // -------------------------------------------------------------
  logic [8:0] lk_cnt_q, lk_cnt_d, lk_div;
  logic [15:0] fcnt_q, fcnt_d;
  logic lk_evt;

  // every div-th edge of the live reference marks a frame; in
  // holdover the counter free-runs on the last phase
  always_comb begin
    lk_div = div_of(rate_of(rate_q, act_idx));
    lk_cnt_d = lk_cnt_q;
    lk_evt = 1'b0;
    if (rise8[act_idx]) begin
      if (lk_cnt_q >= lk_div - 9'h1) begin
        lk_cnt_d = 9'h0;
        lk_evt = (src_q != SRC_HOLD);
      end else begin
        lk_cnt_d = lk_cnt_q + 9'h1;
      end
    end
    if (lk_evt || fcnt_q == 16'(FRAME_CYCLES - 1)) begin
      fcnt_d = 16'h0;
    end else begin
      fcnt_d = fcnt_q + 16'h1;
    end
    frame_start = (fcnt_q == 16'h0);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lk_cnt_q <= 9'h0;
      fcnt_q <= 16'h0;
    end else begin
      lk_cnt_q <= lk_cnt_d;
      fcnt_q <= fcnt_d;
    end
  end

  // -------------------------------------------------------------
  // network reference output
  // -------------------------------------------------------------
  logic [1:0] nsel;
  logic [2:0] nidx;
  logic [8:0] ncnt_q, ncnt_d, ndiv;
  logic nref_raw, nref_q, nref_d;

  // divided form is high for the first half of each frame count
  always_comb begin
    nsel = act_q[`C_NSEL +: 2];
    nidx = {1'b0, nsel} + 3'h1;
    nref_raw = local_timing_refs[nsel];
    ndiv = div_of(rate_of(rate_q, nidx));
    ncnt_d = ncnt_q;
    if (rise8[nidx]) begin
      ncnt_d = (ncnt_q >= ndiv - 9'h1) ? 9'h0 : ncnt_q + 9'h1;
    end
    if (act_q[`C_NDIV] && ndiv != `DIV_8K) begin
      nref_d = (ncnt_q < (ndiv >> 1));
    end else begin
      nref_d = nref_raw;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ncnt_q <= 9'h0;
      nref_q <= 1'b0;
    end else begin
      ncnt_q <= ncnt_d;
      nref_q <= nref_d;
    end
  end

  assign network_ref_out = nref_q;

  // -------------------------------------------------------------
  // derived clocks
  // -------------------------------------------------------------
  // rates above half the system clock alias; a faster clk is
  // needed before the fast output is a true 32/65 MHz square wave
  logic [31:0] hs_inc, sc0_inc, sc1_inc;

  always_comb begin
    hs_inc = act_q[`C_FAST] ? inc_of(`HS65_HZ) : inc_of(`HS32_HZ);
    sc0_inc = sck_inc(act_q[`C_SCK0 +: 2]);
    sc1_inc = sck_inc(act_q[`C_SCK1 +: 2]);
  end

  // all generators restart on the frame so edges share one phase
  nco_clock u_hs (
    .clk(clk),
    .rst_b(rst_b),
    .inc(hs_inc),
    .sync(frame_start),
    .clk_out(high_speed_clock_out)
  );

  nco_clock u_t1 (
    .clk(clk),
    .rst_b(rst_b),
    .inc(inc_of(`T1_HZ)),
    .sync(frame_start),
    .clk_out(t1_rate_clock_out)
  );

  nco_clock u_sc0 (
    .clk(clk),
    .rst_b(rst_b),
    .inc(sc0_inc),
    .sync(frame_start),
    .clk_out(stream_clock_out_0)
  );

  nco_clock u_sc1 (
    .clk(clk),
    .rst_b(rst_b),
    .inc(sc1_inc),
    .sync(frame_start),
    .clk_out(stream_clock_out_1)
  );

  // -------------------------------------------------------------
  // frame pulses and output enables
  // -------------------------------------------------------------
  logic fp0_q, fp0_d, fp1_q, fp1_d;

  always_comb begin
    fp0_d = fcnt_q < {11'h0, fp_cyc(act_q[`C_FPW0 +: 2])};
    fp1_d = fcnt_q < {11'h0, fp_cyc(act_q[`C_FPW1 +: 2])};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fp0_q <= 1'b0;
      fp1_q <= 1'b0;
    end else begin
      fp0_q <= fp0_d;
      fp1_q <= fp1_d;
    end
  end

  assign stream_frame_pulse_out_0 = fp0_q;
  assign stream_frame_pulse_out_1 = fp1_q;

  // the pins float whenever the drive enable input is low
  assign high_speed_clock_out_oe = output_drive_enable;
  assign t1_rate_clock_out_oe = output_drive_enable;
  assign stream_clock_out_0_oe = output_drive_enable;
  assign stream_clock_out_1_oe = output_drive_enable;
  assign stream_frame_pulse_out_0_oe = output_drive_enable;
  assign stream_frame_pulse_out_1_oe = output_drive_enable;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_pri_mirror: assert property (pri_bad |=> primary_failure_out)
    else $error("primary failure pin missed a loss");

  a_sec_mirror: assert property (
    1'b1 |=> secondary_failure_out == $past(sec_bad))
    else $error("secondary failure pin missed a loss");

  a_ode_float: assert property (
    !output_drive_enable |-> !(high_speed_clock_out_oe ||
    t1_rate_clock_out_oe || stream_clock_out_0_oe || stream_clock_out_1_oe ||
    stream_frame_pulse_out_0_oe || stream_frame_pulse_out_1_oe))
    else $error("clock pins driven with drive enable low");

  a_ext_switch: assert property (
    act_q[`C_EXT] && primary_loss_in && !secondary_loss_in
    |=> src_q == SRC_SEC)
    else $error("no switch to secondary on primary loss");

  a_cfg_frame: assert property (!frame_start |=> $stable(act_q))
    else $error("selection changed away from frame boundary");

  a_nref_pass: assert property (
    rst_b && !act_q[`C_NDIV] |=> network_ref_out == $past(nref_raw))
    else $error("network reference not passed through");

  a_fp_start: assert property (
    $rose(stream_frame_pulse_out_0) |-> $past(fcnt_q) == 16'h0)
    else $error("frame pulse not at frame start");

  a_frame_wrap: assert property (
    fcnt_q == 16'(FRAME_CYCLES - 1) |=> fcnt_q == 16'h0)
    else $error("frame counter did not wrap");

  a_sck_align: assert property (
    frame_start |=> !stream_clock_out_0 && !stream_clock_out_1)
    else $error("stream clocks not phased to frame");
endmodule

// [verif/ref_source_model.sv]
// reference sources and loss indicators on the line side of the block
`timescale 1ns/1ps
module ref_source_model (
  input wire logic clk,
  input wire logic [4:0] run,
  input wire logic pri_lost,
  input wire logic sec_lost,
  output logic bus_timing_ref_2,
  output logic [3:0] local_timing_refs,
  output logic primary_loss_in,
  output logic secondary_loss_in
);
  logic [4:0] lvl_q = 5'h00;
  logic [3:0] cnt_q [5] = '{default: 4'h0};
  logic pri_q = 1'b0;
  logic sec_q = 1'b0;

  // -------------------------------------------------------------
  // sources
  // -------------------------------------------------------------
  // source i toggles every i+2 cycles so the five never line up;
  // a stopped source parks low, as a dead oscillator would
  always_ff @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (!run[i]) begin
        lvl_q[i] <= 1'b0;
        cnt_q[i] <= 4'h0;
      end else if (cnt_q[i] == 4'(i + 1)) begin
        lvl_q[i] <= ~lvl_q[i];
        cnt_q[i] <= 4'h0;
      end else begin
        cnt_q[i] <= cnt_q[i] + 4'h1;
      end
    end
    pri_q <= pri_lost;
    sec_q <= sec_lost;
  end

  // loss levels come from framers that only report, never pulse
  assign bus_timing_ref_2 = lvl_q[0];
  assign local_timing_refs = lvl_q[4:1];
  assign primary_loss_in = pri_q;
  assign secondary_loss_in = sec_q;
endmodule

// [verif/testbench.sv]
// self-checking bench for reference selection and derived clocks
`timescale 1ns/1ps
`include "dpll_clk_defines.svh"
module testbench;
  import dpll_clk_pkg::*;
  localparam int FR = 200;
  localparam int LOSS = 400;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ref2;
  logic [3:0] lrefs;
  logic pri_in;
  logic sec_in;
  logic [4:0] run = 5'h1F;
  logic pri_lost = 1'b0;
  logic sec_lost = 1'b0;
  logic output_drive_enable = 1'b1;
  logic net_out;
  logic pri_fail;
  logic sec_fail;
  logic hs;
  logic t1;
  logic sc0;
  logic sc1;
  logic fp0;
  logic fp1;
  logic [5:0] oe;
  logic [31:0] r;
  logic e;
  int mismatches = 0;
  int checks = 0;

  dpll_ref_clocks #(.FRAME_CYCLES(FR), .LOSS_CYCLES(LOSS)) u_dpll_ref_clocks (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_timing_ref_2(ref2),
    .local_timing_refs(lrefs), .primary_loss_in(pri_in),
    .secondary_loss_in(sec_in), .output_drive_enable(output_drive_enable),
    .network_ref_out(net_out), .primary_failure_out(pri_fail),
    .secondary_failure_out(sec_fail), .high_speed_clock_out(hs),
    .high_speed_clock_out_oe(oe[0]), .t1_rate_clock_out(t1),
    .t1_rate_clock_out_oe(oe[1]), .stream_clock_out_0(sc0),
    .stream_clock_out_0_oe(oe[2]), .stream_clock_out_1(sc1),
    .stream_clock_out_1_oe(oe[3]), .stream_frame_pulse_out_0(fp0),
    .stream_frame_pulse_out_0_oe(oe[4]), .stream_frame_pulse_out_1(fp1),
    .stream_frame_pulse_out_1_oe(oe[5]));

  ref_source_model u_ref_source_model (
    .clk(clk), .run(run), .pri_lost(pri_lost), .sec_lost(sec_lost),
    .bus_timing_ref_2(ref2), .local_timing_refs(lrefs),
    .primary_loss_in(pri_in), .secondary_loss_in(sec_in));

  // -------------------------------------------------------------
  // common tasks
  // -------------------------------------------------------------
  // tol gives slack for counts of jittery synthesised clocks
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp, input int tol = 0);
    logic ok;
    checks++;
    ok = (tol == 0) ? (seen === exp) :
         (seen + tol >= exp && seen <= exp + tol);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no wait count is assumed; only the watchdog ends a stuck access
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl(input int ext, input int high_speed_clock_select_bit,
      input int nsel, input int ssel, input int k0, input int k1);
    return (32'(ext) << `C_EXT) | (32'(high_speed_clock_select_bit) << `C_FAST) |
      (32'(nsel) << `C_NSEL) | (32'(ssel) << `C_SSEL) |
      (32'(k0) << `C_SCK0) | (32'(k1) << `C_SCK1) |
      (32'(k0) << `C_FPW0) | (32'(k1) << `C_FPW1);
  endfunction

  // rising edges per frame of an accumulator msb, folded at clk rate
  function automatic int edges(input real mhz);
    real f;
    f = mhz * 0.02;
    f = f - $floor(f);
    if (f > 0.5) f = 1.0 - f;
    return $rtoi(f * FR + 0.5);
  endfunction

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, `CTRL_OFS, 32'h0, r, e);
    check("ctrl reset", r, `CTRL_RST);
    apb(1'b0, `RATE_OFS, 32'h0, r, e);
    check("rate reset", r, 32'(`RATE_RST));
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, r, e);
    check("unmapped write error", 32'(e), 32'h1);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    check("unmapped read error", 32'(e), 32'h1);
    check("unmapped read data", r, 32'h0);
    apb(1'b1, `RATE_OFS, 32'h00000099, r, e);
    apb(1'b0, `RATE_OFS, 32'h0, r, e);
    check("rate readback", r, 32'h00000099);
    apb(1'b1, `RATE_OFS, 32'h0, r, e);
    $display("test registers done");
  endtask

  task automatic t_oe();
    for (int v = 0; v < 2; v++) begin
      output_drive_enable <= v[0];
      repeat (2) @(posedge clk);
      check("output enables", 32'(oe), {26'h0, {6{v[0]}}});
    end
    $display("test drive enable done");
  endtask

  // external switching: loss pins drive status bits and failure pins
  task automatic t_loss_ext();
    apb(1'b1, `CTRL_OFS, ctrl(1, 0, 0, 1, 0, 0), r, e);
    repeat (FR + 10) @(posedge clk);
    pri_lost <= 1'b1;
    repeat (4) @(posedge clk);
    check("primary failure", 32'(pri_fail), 32'h1);
    check("secondary failure", 32'(sec_fail), 32'h0);
    apb(1'b0, `STAT_OFS, 32'h0, r, e);
    check("loss status", 32'(r[1:0]), 32'h1);
    sec_lost <= 1'b1;
    repeat (4) @(posedge clk);
    check("secondary failure", 32'(sec_fail), 32'h1);
    apb(1'b0, `STAT_OFS, 32'h0, r, e);
    check("loss status", 32'(r[2:0]), 32'h7);
    $display("test external loss done");
  endtask

  // in holdover the frame is timed locally; every code is visited
  task automatic t_clocks();
    int n, per, w0, w1, c0, c1, ch, ct;
    logic p0, p1, ph, pt, pf;
    real mhz [3] = '{4.096, 8.192, 16.384};
    int ns [3] = '{244, 122, 61};
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `CTRL_OFS, ctrl(1, k == 1, 0, 1, k, 2 - k), r, e);
      repeat (FR + 5) @(posedge clk);
      n = 0;
      pf = 1'b1;
      while (!(fp0 === 1'b1 && pf === 1'b0) && n < 2 * FR) begin
        pf = fp0;
        @(posedge clk);
        n++;
      end
      check("clocks at pulse", 32'({sc0, sc1, hs, t1}), 32'h0);
      {per, w0, w1, c0, c1, ch, ct} =
        {32'h0, 32'h1, 32'(fp1 === 1'b1), 128'h0};
      {p0, p1, ph, pt, pf} = {sc0, sc1, hs, t1, fp0};
      for (int c = 1; c < 2 * FR && per == 0; c++) begin
        @(posedge clk);
        if (fp0 === 1'b1 && pf === 1'b0) per = c;
        else begin
          w0 += (fp0 === 1'b1);
          w1 += (fp1 === 1'b1);
          c0 += (sc0 === 1'b1 && p0 === 1'b0);
          c1 += (sc1 === 1'b1 && p1 === 1'b0);
          ch += (hs === 1'b1 && ph === 1'b0);
          ct += (t1 === 1'b1 && pt === 1'b0);
        end
        {p0, p1, ph, pt, pf} = {sc0, sc1, hs, t1, fp0};
      end
      check("frame period", per, FR);
      check("pulse width 0", w0, (ns[k] + 19) / 20);
      check("pulse width 1", w1, (ns[2 - k] + 19) / 20);
      check("stream clock 0", c0, edges(mhz[k]), 1);
      check("stream clock 1", c1, edges(mhz[2 - k]), 1);
      check("fast clock", ch, edges(k == 1 ? 65.536 : 32.768), 1);
      check("t1 clock", ct, edges(1.544), 1);
    end
    $display("test derived clocks done");
  endtask

  // monitor mode: network output follows local ref 1, then ref 2 dies
  task automatic t_network();
    logic exp;
    int n;
    pri_lost <= 1'b0;
    sec_lost <= 1'b0;
    apb(1'b1, `CTRL_OFS, ctrl(0, 0, 1, 1, 0, 0), r, e);
    repeat (2 * FR) @(posedge clk);
    exp = lrefs[1];
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      check("network raw", 32'(net_out), 32'(exp));
      exp = lrefs[1];
    end
    check("primary good", 32'(pri_fail), 32'h0);
    run <= 5'h1E;
    repeat (LOSS + 60) @(posedge clk);
    check("primary failure", 32'(pri_fail), 32'h1);
    apb(1'b0, `STAT_OFS, 32'h0, r, e);
    check("active after loss", 32'(r[5:3]), 32'h1);
    // local ref 1 as 2.048M, divided: a rise every 8 cycles, so one
    // full period of the divided output is 2048 cycles, half of it high
    apb(1'b1, `RATE_OFS, 32'h00000020, r, e);
    apb(1'b1, `CTRL_OFS, ctrl(0, 0, 1, 1, 0, 0) | (32'h1 << `C_NDIV), r, e);
    repeat (40) @(posedge clk);
    n = 0;
    repeat (2048) begin
      @(posedge clk);
      n += (net_out === 1'b1);
    end
    check("network divided", n, 32'(`DIV_E1) << 2);
    $display("test network and monitor done");
  endtask

  // -------------------------------------------------------------
  // run control
  // -------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    forever #10 clk = ~clk;
  end

  // the whole run is a few thousand cycles; allow several times that
  initial begin
    #400000;
    mismatches++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_oe();
    t_loss_ext();
    t_clocks();
    t_network();
    final_report();
  end
endmodule
